// [hw/irq_ctrl_cfg.svh]
// Constants for the interrupt mask and nesting controller
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH
`define ADDR_LATCH      4'h0
`define ADDR_MASK       4'h1
`define ADDR_POINTER    4'h2
`define ADDR_FIRST_MODE_CONTROL      4'h3
`define ADDR_SECOND_MODE_CONTROL      4'h4
`define ADDR_ARITH_STATUS      4'h5
`define ADDR_STICKY     4'h6
`define ADDR_STACK_CMD  4'h7
`define ADDR_SERVICE    4'h8
`define BIT_GIE         12
`define BIT_NESTING_MODE_BIT       11
`define BIT_IRQ0        8
`define BIT_TIMER_HIGH_PRIO_INT       4
`define BIT_TIMER_LOW_PRIO_INT       23
`define BIT_DMA8        16
`define BIT_SW_LO       28
`define BIT_FIX_OVF     17
`define BIT_FLT_OVF     18
`define BIT_FLT_UNF     19
`define BIT_FLT_INV     20
`define BIT_VECTOR_INT_REGISTER       1
`define STICKY_STATUS_FIX_OVF    2
`define STICKY_STATUS_FLT_OVF    5
`define STICKY_STATUS_FLT_UNF    6
`define STICKY_STATUS_FLT_INV    7
`define SECOND_MODE_CONTROL_TPRIO0    5
`define SECOND_MODE_CONTROL_TPRIO1    6
`define ARITH_STATUS_FLAG_LO   19
`define MASK_RESET      32'h0001_0000
`define STACK_DEPTH     5
`endif

// [hw/irq_ctrl_pkg.sv]
// Types for the interrupt mask and nesting controller
`default_nettype none
package irq_ctrl_pkg;
  typedef logic [31:0] word_t;
  typedef logic [3:0]  addr_t;
  typedef enum logic [1:0] {ST_RUN, ST_DEFER} take_state_t;
endpackage
`default_nettype wire

// [hw/irq_mask_nesting.sv]
// Interrupt latch, mask, nesting pointer and status stack for the core sequencer
`include "irq_ctrl_cfg.svh"
`default_nettype none
module irq_mask_nesting (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                ce,
  input  wire logic                bootUnmask,
  input  wire logic [2:0]          extIntRequestN,
  input  wire logic                timerEvent0,
  input  wire logic                timerEvent1,
  input  wire logic                vectorIntReq,
  input  wire logic                returnFromInt,
  input  wire logic                jumpClearInt,
  input  wire logic                takeAck,
  input  wire logic [31:0]         stickyStatusIn,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  input  wire irq_ctrl_pkg::addr_t regAddr,
  input  wire irq_ctrl_pkg::word_t regWriteData,
  output logic [31:0]              regReadData,
  output logic                     intRequest,
  output logic [4:0]               intVector,
  output logic                     statusPush
);
  import irq_ctrl_pkg::*;

  // -------------------------------------------------------------
  // Helper functions
  // -------------------------------------------------------------
  // Lowest set index is the highest priority; 32 stands for no bit set
  function automatic logic [5:0] first_set(input word_t v);
    logic [5:0] r;
    r = 6'h20;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  // Ones at every position of strictly higher priority than idx
  function automatic word_t below_mask(input logic [5:0] idx);
    word_t m;
    m = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (6'(i) < idx) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  function automatic logic pushes(input logic [4:0] idx);
    return (idx == 5'(`BIT_TIMER_HIGH_PRIO_INT)) || (idx == 5'(`BIT_VECTOR_INT_REGISTER)) ||
           (idx >= 5'(`BIT_IRQ0) && idx <= 5'(`BIT_IRQ0 + 2));
  endfunction

  // Register strobe qualified by address; shared by every write decode
  function automatic logic reg_hit(input logic strobe, input addr_t a, input addr_t target);
    return strobe && (a == target);
  endfunction

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  word_t       latch;
  word_t       enableMask;
  word_t       pointer;
  word_t       first_mode_control;
  word_t       second_mode_control;
  word_t       astatStack [`STACK_DEPTH];
  word_t       mode1Stack [`STACK_DEPTH];
  logic [2:0]  stackPtr;
  logic [2:0]  syncA;
  logic [2:0]  syncB;
  logic [2:0]  prevSample;
  logic        lastTakeLow;
  logic [5:0]  lastTakeIdx;
  take_state_t takeState;
  take_state_t next_takeState;

  // -------------------------------------------------------------
  // Register write decode
  // -------------------------------------------------------------
  // Each decode compares regAddr with a different address, so at most one of these is high
  wire        wrLatch     = reg_hit(regWrite, regAddr, `ADDR_LATCH);
  wire        wrMask      = reg_hit(regWrite, regAddr, `ADDR_MASK);
  wire        wrMode1     = reg_hit(regWrite, regAddr, `ADDR_FIRST_MODE_CONTROL);
  wire        wrMode2     = reg_hit(regWrite, regAddr, `ADDR_SECOND_MODE_CONTROL);
  wire        wrAstat     = reg_hit(regWrite, regAddr, `ADDR_ARITH_STATUS);
  wire        swWrite     = reg_hit(regWrite, regAddr, `ADDR_STACK_CMD);
  // A take is the acknowledge landing on a standing offer
  wire        takeNow     = takeAck && intRequest;
  wire        leaveNow    = returnFromInt || jumpClearInt;

  // -------------------------------------------------------------
  // Event sources
  // -------------------------------------------------------------
  // the core clock runs at twice the input clock, so each core edge is one sample
  // Limitation: a pin pulse shorter than one core clock may slip past the synchroniser
  wire [2:0] pinLow      = ~syncB;
  wire [2:0] edgeSel     = second_mode_control[2:0];
  wire [2:0] pinEdge     = prevSample & pinLow;
  wire [2:0] pinValid    = (edgeSel & pinEdge) | (~edgeSel & pinLow);
  wire       t0High      = second_mode_control[`SECOND_MODE_CONTROL_TPRIO0];
  wire       t1High      = second_mode_control[`SECOND_MODE_CONTROL_TPRIO1];
  wire       timerHi     = (timerEvent0 & t0High) | (timerEvent1 & t1High);
  wire       timerLo     = (timerEvent0 & ~t0High) | (timerEvent1 & ~t1High);

  word_t hwEvents;
  always_comb begin
    hwEvents = 32'h0000_0000;
    hwEvents[`BIT_IRQ0 +: 3]   = pinValid;
    hwEvents[`BIT_TIMER_HIGH_PRIO_INT]       = timerHi;
    hwEvents[`BIT_TIMER_LOW_PRIO_INT]       = timerLo;
    hwEvents[`BIT_VECTOR_INT_REGISTER]       = vectorIntReq;
    hwEvents[`BIT_FIX_OVF]     = stickyStatusIn[`STICKY_STATUS_FIX_OVF];
    hwEvents[`BIT_FLT_OVF]     = stickyStatusIn[`STICKY_STATUS_FLT_OVF];
    hwEvents[`BIT_FLT_UNF]     = stickyStatusIn[`STICKY_STATUS_FLT_UNF];
    hwEvents[`BIT_FLT_INV]     = stickyStatusIn[`STICKY_STATUS_FLT_INV];
  end

  // -------------------------------------------------------------
  // Priority and masking
  // -------------------------------------------------------------
  wire        nestOn      = first_mode_control[`BIT_NESTING_MODE_BIT];
  wire [5:0]  curLevel    = first_set(pointer);
  wire        inService   = (pointer != 32'h0000_0000);
  // only positions above the current level keep their mask bit
  wire word_t nestMask    = enableMask & below_mask(curLevel);
  // without nesting everything waits until the routine ends
  wire word_t effMask     = !inService ? enableMask : (nestOn ? nestMask : 32'h0000_0000);
  wire word_t pending     = latch & effMask & {32{first_mode_control[`BIT_GIE]}};
  wire [5:0]  winner      = first_set(pending);
  // a preemption of the routine just entered waits one cycle
  wire        deferNow    = lastTakeLow && (winner < lastTakeIdx);
  wire        canTake     = (winner != 6'h20) && !deferNow && (takeState == ST_RUN);
  wire [4:0]  topIdx      = curLevel[4:0];
  wire        topPushed   = inService && pushes(topIdx);
  // Level 32 means no routine runs; software reads it to find the current one
  wire word_t serviceWord = {26'h0, curLevel};

  // -------------------------------------------------------------
  // Status stack control
  // -------------------------------------------------------------
  wire        doPush      = (takeNow && pushes(intVector)) || (swWrite && regWriteData[0]);
  wire        doPop       = (leaveNow && topPushed) || (swWrite && regWriteData[1]);

  // -------------------------------------------------------------
  // Stack bookkeeping
  // -------------------------------------------------------------
  // Slot stackPtr is the live level; a full stack drops pushes and an empty one ignores pops,
  // which keeps every index inside the storage
  wire        stackRoom   = (stackPtr < 3'(`STACK_DEPTH - 1));
  wire        stackHeld   = (stackPtr != 3'h0);
  wire        pushGo      = doPush && stackRoom;
  wire        popGo       = doPop && stackHeld && !pushGo;
  wire [2:0]  pushSlot    = stackPtr + 3'h1;
  wire [2:0]  popSlot     = stackPtr - 3'h1;
  wire word_t flagKeep    = 32'h0000_000F << `ARITH_STATUS_FLAG_LO;

  // -------------------------------------------------------------
  // Next latch and pointer
  // -------------------------------------------------------------
  word_t next_latch;
  word_t next_pointer;
  word_t topBit;
  always_comb begin
    topBit = 32'h0000_0000;
    if (inService) begin
      topBit[topIdx] = 1'b1;
    end
    next_latch = latch;
    if (wrLatch) begin
      next_latch = regWriteData;
    end
    next_pointer = pointer;
    if (takeNow) begin
      next_pointer[intVector] = 1'b1;
    end
    if (leaveNow) begin
      next_pointer = next_pointer & ~topBit;
    end
    if (inService && !jumpClearInt) begin
      next_latch = next_latch & ~topBit;
    end
    if (jumpClearInt) begin
      next_latch = next_latch & ~topBit;
    end
    // Hardware sets win over any clear in the same cycle, except at the bit of the level in service
    next_latch = next_latch | (hwEvents & ~(inService ? topBit : 32'h0000_0000));
  end

  // -------------------------------------------------------------
  // Sequential state
  // -------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      syncA      <= 3'h7;
      syncB      <= 3'h7;
    end else if (ce) begin
      syncA      <= extIntRequestN;
      syncB      <= syncA;
    end
  end

  // Reset low, but syncB resets high, so a pin held low through reset is still taken as a fresh edge
  always_ff @(posedge clk) begin
    if (srst) begin
      prevSample <= 3'h0;
    end else if (ce) begin
      prevSample <= syncB;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      latch   <= 32'h0000_0000;
    end else if (ce) begin
      latch   <= next_latch;
    end
  end

  // The pointer records every level entered; software cannot write it
  always_ff @(posedge clk) begin
    if (srst) begin
      pointer <= 32'h0000_0000;
    end else if (ce) begin
      pointer <= next_pointer;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      enableMask <= `MASK_RESET;
    end else if (ce) begin
      if (wrMask) begin
        enableMask <= regWriteData;
      end else if (bootUnmask) begin
        enableMask[`BIT_DMA8] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      second_mode_control <= 32'h0000_0000;
    end else if (ce && wrMode2) begin
      second_mode_control <= regWriteData;
    end
  end

  // A pop restores the interrupted program's modes and beats a software write
  always_ff @(posedge clk) begin
    if (srst) begin
      first_mode_control <= 32'h0000_0000;
    end else if (ce) begin
      if (popGo) begin
        first_mode_control <= mode1Stack[popSlot];
      end else if (wrMode1) begin
        first_mode_control <= regWriteData;
      end
    end
  end

  // ARITH_STATUS top is slot stackPtr; user flags always come from the live top
  always_ff @(posedge clk) begin
    if (srst) begin
      stackPtr <= 3'h0;
      for (int i = 0; i < `STACK_DEPTH; i++) begin
        astatStack[i] <= 32'h0000_0000;
        mode1Stack[i] <= 32'h0000_0000;
      end
    end else if (ce) begin
      if (pushGo) begin
        astatStack[pushSlot]        <= astatStack[stackPtr];
        mode1Stack[stackPtr]        <= first_mode_control;
        stackPtr                    <= pushSlot;
      end else if (popGo) begin
        astatStack[popSlot]         <= (astatStack[popSlot] & ~flagKeep) |
                                       (astatStack[stackPtr] & flagKeep);
        stackPtr                    <= popSlot;
      end else if (wrAstat) begin
        astatStack[stackPtr] <= regWriteData;
      end
    end
  end

  // -------------------------------------------------------------
  // Offer state
  // -------------------------------------------------------------
  // One idle cycle after every take lets the pointer settle before the next offer
  always_comb begin
    case (takeState)
      ST_RUN: begin
        next_takeState = takeNow ? ST_DEFER : ST_RUN;
      end
      ST_DEFER: begin
        next_takeState = ST_RUN;
      end
      default: begin
        next_takeState = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      takeState <= ST_RUN;
    end else if (ce) begin
      takeState <= next_takeState;
    end
  end

  // -------------------------------------------------------------
  // Request to the sequencer
  // -------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      intRequest  <= 1'b0;
      intVector   <= 5'h00;
      statusPush  <= 1'b0;
    end else if (ce) begin
      intRequest  <= canTake && !takeNow;
      intVector   <= winner[4:0];
      statusPush  <= canTake && pushes(winner[4:0]);
    end
  end

  // Remembers the level just entered so a higher request waits one cycle, the same cycle as ST_DEFER
  always_ff @(posedge clk) begin
    if (srst) begin
      lastTakeLow <= 1'b0;
      lastTakeIdx <= 6'h20;
    end else if (ce) begin
      lastTakeLow <= takeNow && nestOn;
      lastTakeIdx <= {1'b0, intVector};
    end
  end

  // -------------------------------------------------------------
  // Register read
  // -------------------------------------------------------------
  word_t readMux;
  always_comb begin
    case (regAddr)
      `ADDR_LATCH:   readMux = latch;
      `ADDR_MASK:    readMux = enableMask;
      `ADDR_POINTER: readMux = pointer;
      `ADDR_FIRST_MODE_CONTROL:   readMux = first_mode_control;
      `ADDR_SECOND_MODE_CONTROL:   readMux = second_mode_control;
      `ADDR_ARITH_STATUS:   readMux = astatStack[stackPtr];
      `ADDR_STICKY:  readMux = stickyStatusIn;
      `ADDR_SERVICE: readMux = serviceWord;
      default:       readMux = 32'h0000_0000;
    endcase
  end

  // Zero outside a read slot, so several readers can share one return path
  wire word_t readNext    = regRead ? readMux : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (srst) begin
      regReadData <= 32'h0000_0000;
    end else if (ce) begin
      regReadData <= readNext;
    end
  end
endmodule
`default_nettype wire

// [dv/irq_mask_nesting_properties.sv]
// Port-level assertions for the interrupt mask and nesting controller
`include "irq_ctrl_cfg.svh"
`default_nettype none
module irq_mask_nesting_properties (
  input wire logic                clk,
  input wire logic                srst,
  input wire logic                ce,
  input wire logic                returnFromInt,
  input wire logic                jumpClearInt,
  input wire logic                takeAck,
  input wire logic                regWrite,
  input wire logic                regRead,
  input wire irq_ctrl_pkg::addr_t regAddr,
  input wire irq_ctrl_pkg::word_t regWriteData,
  input wire logic [31:0]         regReadData,
  input wire logic                intRequest,
  input wire logic [4:0]          intVector,
  input wire logic                statusPush
);
  import irq_ctrl_pkg::*;
  logic       seenGie;
  logic       serving;
  logic [4:0] servVec;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Tracks the last taken vector; a nested return only weakens the check
  always_ff @(posedge clk) begin
    if (srst) begin
      seenGie <= 1'b0;
      serving <= 1'b0;
      servVec <= 5'h0;
    end else if (ce) begin
      if (regWrite && regAddr == `ADDR_FIRST_MODE_CONTROL && regWriteData[`BIT_GIE]) seenGie <= 1'b1;
      if (takeAck && intRequest) serving <= 1'b1;
      else if (returnFromInt || jumpClearInt) serving <= 1'b0;
      if (takeAck && intRequest) servVec <= intVector;
    end
  end
  sequence s_take;
    takeAck && intRequest;
  endsequence
  chk_read_idle: assert property (!regRead |=> regReadData == 32'h0)
    else $error("read data seen outside read slot");
  chk_unmapped_zero: assert property (regRead && regAddr > 4'h8 |=> regReadData == 32'h0)
    else $error("unmapped read returned data");
  chk_offer_holds: assert property (intRequest && !takeAck && ce |=> intRequest)
    else $error("offer withdrawn before acknowledge");
  chk_ack_drop: assert property (s_take |=> !intRequest)
    else $error("offer still high after acknowledge");
  chk_push_kind: assert property (intRequest |-> statusPush == (intVector inside {5'd1, 5'd4, 5'd8, 5'd9, 5'd10}))
    else $error("status push flag wrong for vector");
  chk_enable_first: assert property (intRequest |-> seenGie)
    else $error("offer without global enable ever set");
  chk_reset_quiet: assert property ($fell(srst) |-> !intRequest && !statusPush)
    else $error("offer right after reset");
  chk_no_revector: assert property (serving |-> !(intRequest && intVector == servVec))
    else $error("vector offered again during its service");
endmodule
bind irq_mask_nesting irq_mask_nesting_properties irq_mask_nesting_properties_i (
  .clk(clk), .srst(srst), .ce(ce), .returnFromInt(returnFromInt), .jumpClearInt(jumpClearInt),
  .takeAck(takeAck), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
  .regReadData(regReadData), .intRequest(intRequest), .intVector(intVector), .statusPush(statusPush));
`default_nettype wire

// [dv/seq_partner.sv]
// Sequencer stand-in that takes offered interrupts after a set delay
`default_nettype none
module seq_partner (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       intRequest,
  input  wire logic [4:0] intVector,
  input  wire logic       statusPush,
  input  wire logic [3:0] ackDelay,
  output logic            takeAck,
  output logic [4:0]      lastVec,
  output logic            lastPush,
  output logic [7:0]      takes
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] waitN;
  // Acks only while offered, so an ack never lands on a withdrawn request
  always @(posedge clk) begin
    if (srst) begin
      takeAck <= 1'b0;
      waitN <= 4'h0;
      takes <= 8'h0;
    end else if (takeAck) begin
      takeAck <= 1'b0;
    end else if (intRequest && waitN >= ackDelay) begin
      takeAck <= 1'b1;
      lastVec <= intVector;
      lastPush <= statusPush;
      takes <= takes + 8'h1;
      waitN <= 4'h0;
    end else begin
      waitN <= intRequest ? waitN + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// [dv/dsp_interrupt_mask_nesting_tb.sv]
// Self-checking bench for the interrupt mask and nesting controller
`include "irq_ctrl_cfg.svh"
`default_nettype none
module dsp_interrupt_mask_nesting_tb;
  import irq_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, srst, ce, bootUnmask, timerEvent0, timerEvent1, vectorIntReq, returnFromInt, jumpClearInt;
  logic        takeAck, regWrite, regRead, intRequest, statusPush, lastPush;
  logic [2:0]  extIntRequestN;
  logic [4:0]  intVector, lastVec;
  logic [3:0]  ackDelay;
  logic [7:0]  takes;
  logic [31:0] stickyStatusIn, regReadData;
  addr_t       regAddr;
  word_t       regWriteData, m, l;
  int          fail_count, num_checks;
  irq_mask_nesting irq_mask_nesting_i (.clk(clk), .srst(srst), .ce(ce), .bootUnmask(bootUnmask),
    .extIntRequestN(extIntRequestN), .timerEvent0(timerEvent0), .timerEvent1(timerEvent1),
    .vectorIntReq(vectorIntReq), .returnFromInt(returnFromInt), .jumpClearInt(jumpClearInt), .takeAck(takeAck),
    .stickyStatusIn(stickyStatusIn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWriteData(regWriteData), .regReadData(regReadData), .intRequest(intRequest), .intVector(intVector),
    .statusPush(statusPush));
  seq_partner seq_partner_i (.clk(clk), .srst(srst), .intRequest(intRequest), .intVector(intVector),
    .statusPush(statusPush), .ackDelay(ackDelay), .takeAck(takeAck), .lastVec(lastVec), .lastPush(lastPush),
    .takes(takes));
  always #4 clk = ~clk;
  function automatic int low(input logic [31:0] v);
    for (int b = 0; b < 32; b++) if (v[b]) return b;
    return 32;
  endfunction
  task automatic summarize();
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input addr_t a, input word_t d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input addr_t a, input word_t e, input string n);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(n, regReadData, e);
  endtask
  task automatic take(input logic [4:0] e, input logic p);
    logic [7:0] t0;
    t0 = takes;
    for (int i = 0; i < 60 && takes == t0; i++) @(posedge clk);
    if (takes == t0) begin
      fail_count++;
      $display("Error take expected %h seen none", e);
      summarize();
    end
    chk("vector", lastVec, e);
    chk("push", lastPush, p);
  endtask
  task automatic none(input int k);
    logic [7:0] t0;
    t0 = takes;
    repeat (k) @(posedge clk);
    chk("no take", takes, t0);
  endtask
  task automatic ret(input logic ci);
    @(posedge clk);
    {jumpClearInt, returnFromInt} <= ci ? 2'b10 : 2'b01;
    @(posedge clk);
    {jumpClearInt, returnFromInt} <= 2'b00;
  endtask
  initial begin
    {clk, ce, bootUnmask, srst} = 4'b0101;
    {timerEvent0, timerEvent1, vectorIntReq, returnFromInt, jumpClearInt, regWrite, regRead} = 7'h0;
    extIntRequestN = 3'b111;
    {ackDelay, stickyStatusIn, regAddr, regWriteData} = 72'h0;
    {fail_count, num_checks} = 64'h0;
    void'($urandom(47));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(`ADDR_MASK, `MASK_RESET, "mask");
    rd(4'hF, 32'h0, "unmapped");
    wr(`ADDR_LATCH, 32'h1000_0000);
    none(8);
    rd(`ADDR_LATCH, 32'h1000_0000, "latch");
    wr(`ADDR_MASK, 32'hFFFF_FFFF);
    none(8);
    wr(`ADDR_FIRST_MODE_CONTROL, 32'h0000_1000);
    take(5'd28, 1'b0);
    rd(`ADDR_POINTER, 32'h1000_0000, "pointer");
    wr(`ADDR_LATCH, 32'h1000_0000);
    none(6);
    rd(`ADDR_LATCH, 32'h0, "latch");
    ret(1'b1);
    wr(`ADDR_LATCH, 32'h1000_0000);
    take(5'd28, 1'b0);
    ret(1'b0);
    rd(`ADDR_POINTER, 32'h0, "pointer");
    wr(`ADDR_LATCH, 32'h6000_0000);
    take(5'd29, 1'b0);
    none(8);
    rd(`ADDR_POINTER, 32'h2000_0000, "pointer");
    ret(1'b0);
    take(5'd30, 1'b0);
    ret(1'b0);
    wr(`ADDR_FIRST_MODE_CONTROL, 32'h0000_1800);
    wr(`ADDR_LATCH, 32'h4000_0000);
    take(5'd30, 1'b0);
    wr(`ADDR_LATCH, 32'hA000_0000);
    take(5'd29, 1'b0);
    none(8);
    rd(`ADDR_POINTER, 32'h6000_0000, "pointer");
    ret(1'b0);
    none(6);
    rd(`ADDR_POINTER, 32'h4000_0000, "pointer");
    ret(1'b0);
    take(5'd31, 1'b0);
    ret(1'b0);
    wr(`ADDR_FIRST_MODE_CONTROL, 32'h0000_1000);
    for (int t = 0; t < 3; t++) begin
      wr(`ADDR_SECOND_MODE_CONTROL, t < 2 ? 32'h20 << t : 32'h0);
      {timerEvent1, timerEvent0} <= t < 2 ? 2'b01 << t : 2'b11;
      @(posedge clk);
      {timerEvent1, timerEvent0} <= 2'b00;
      take(t < 2 ? 5'd4 : 5'd23, t < 2);
      ret(1'b0);
      none(8);
    end
    vectorIntReq <= 1'b1;
    @(posedge clk);
    vectorIntReq <= 1'b0;
    take(5'd1, 1'b1);
    ret(1'b0);
    wr(`ADDR_SECOND_MODE_CONTROL, 32'h1);
    extIntRequestN <= 3'b110;
    take(5'd8, 1'b1);
    ret(1'b0);
    none(10);
    extIntRequestN <= 3'b101;
    take(5'd9, 1'b1);
    ret(1'b0);
    take(5'd9, 1'b1);
    extIntRequestN <= 3'b111;
    repeat (6) @(posedge clk);
    ret(1'b0);
    none(8);
    stickyStatusIn <= 32'h4;
    take(5'd17, 1'b0);
    ret(1'b0);
    take(5'd17, 1'b0);
    stickyStatusIn <= 32'h0;
    wr(`ADDR_LATCH, 32'h0);
    ret(1'b0);
    none(8);
    for (int i = 0; i < 6; i++) begin
      m = $urandom;
      l = $urandom & 32'hF000_0000;
      ackDelay <= 4'($urandom % 4);
      wr(`ADDR_MASK, m);
      wr(`ADDR_LATCH, l);
      if ((m & l) != 0) begin
        take(5'(low(m & l)), 1'b0);
        wr(`ADDR_LATCH, 32'h0);
        ret(1'b0);
      end else none(8);
    end
    wr(`ADDR_ARITH_STATUS, 32'h0078_0001);
    rd(`ADDR_ARITH_STATUS, 32'h0078_0001, "arith_status");
    wr(`ADDR_STACK_CMD, 32'h1);
    wr(`ADDR_ARITH_STATUS, 32'h0);
    wr(`ADDR_STACK_CMD, 32'h2);
    rd(`ADDR_ARITH_STATUS, 32'h0000_0001, "arith_status");
    summarize();
  end
endmodule
`default_nettype wire
